//--- design/bads_pkg.sv
package bads_pkg;

    // Address space geometry.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NEAR_W = 13;
    localparam int WORD_ADDR_W = 12;
    localparam int PSV_BIT = 15;
    localparam logic [15:0] RAM_BYTES = 16'h2400;
    localparam logic [15:0] PERIPH_LAST = 16'h07ff;
    localparam logic [15:0] NEAR_LAST = 16'h1fff;
    localparam logic [15:0] RAM_FIRST = 16'h0800;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    // Operations applied to a working register value.
    typedef enum logic [1:0] {
        BADS_OP_PASS = 2'b00,
        BADS_OP_SIGN = 2'b01,
        BADS_OP_CLEAR_HIGH = 2'b10,
        BADS_OP_LOAD_BYTE = 2'b11
    } bads_op_t;

    // One data-space request from an address generator.
    typedef struct packed {
        logic valid;
        logic is_byte;
        logic [15:0] addr;
        logic [15:0] data;
    } bads_req_t;

    // Region decode of an address.
    typedef struct packed {
        logic periph;
        logic near;
        logic psv;
        logic ram;
    } bads_region_t;

endpackage

//--- design/bads_core.sv
`timescale 1ns/1ps
`default_nettype none

module bads_core #(
    parameter int RAM_WORDS = 4608
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire bads_pkg::bads_req_t rd_req_in,
    input wire bads_pkg::bads_req_t wr_req_in,
    input wire logic near_mode_in,
    input wire logic [12:0] near_addr_in,
    input wire logic [15:0] ptr_in,
    input wire logic ptr_inc_in,
    input wire logic [15:0] periph_rdata_in,
    input wire logic periph_hit_in,
    input wire logic [15:0] psv_rdata_in,
    input wire bads_pkg::bads_op_t reg_op_in,
    input wire logic [15:0] reg_value_in,
    input wire logic [7:0] reg_byte_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic [15:0] ptr_next_out,
    output logic [15:0] reg_result_out,
    output logic periph_wr_out,
    output logic [1:0] periph_lane_we_out,
    output logic [15:0] periph_addr_out,
    output logic [15:0] periph_wdata_out,
    output logic psv_rd_out,
    output logic addr_error_out,
    output logic addr_error_write_out,
    output logic [15:0] error_addr_out
);

    logic [7:0] lane_lo [RAM_WORDS];
    logic [7:0] lane_hi [RAM_WORDS];
    logic [15:0] rd_addr;
    bads_pkg::bads_region_t rd_reg;
    bads_pkg::bads_region_t wr_reg;
    logic rd_misaligned;
    logic wr_misaligned;
    logic wr_do;
    logic [1:0] lane_we;
    logic [15:0] rd_word;
    logic rd_byte_reg;
    logic rd_sel_hi_reg;
    logic rd_hit_reg;
    logic rd_psv_reg;
    logic rd_periph_reg;
    logic rd_pend_reg;
    logic [15:0] mem_word_reg;

    // Decodes an address into its regions; shared by both generators.
    function automatic bads_pkg::bads_region_t decode(input logic [15:0] a);
        bads_pkg::bads_region_t r;
        r.psv = a[bads_pkg::PSV_BIT];
        r.periph = a <= bads_pkg::PERIPH_LAST;
        r.near = a <= bads_pkg::NEAR_LAST;
        r.ram = (a >= bads_pkg::RAM_FIRST) && (a < bads_pkg::RAM_BYTES);
        return r;
    endfunction

    // Word index of a byte address inside the RAM lanes.
    function automatic logic [11:0] word_index(input logic [15:0] a);
        return a[12:1];
    endfunction

    // The near field is zero-extended; direct or pointer reads use all 16 bits.
    assign rd_addr = near_mode_in ? {3'h0, near_addr_in} : rd_req_in.addr;
    assign rd_reg = decode(rd_addr);
    assign wr_reg = decode(wr_req_in.addr);

    // Only word accesses care about bit zero.
    assign rd_misaligned = rd_req_in.valid && !rd_req_in.is_byte && rd_addr[0];
    assign wr_misaligned = wr_req_in.valid && !wr_req_in.is_byte && wr_req_in.addr[0];
    assign wr_do = wr_req_in.valid && !wr_misaligned;

    // Lane strobes: a byte touches one lane, a word both.
    always_comb begin
        lane_we = 2'h0;
        if (wr_do) begin
            if (wr_req_in.is_byte) begin
                lane_we = wr_req_in.addr[0] ? 2'h2 : 2'h1;
            end else begin
                lane_we = 2'h3;
            end
        end
    end

    // Byte data rides on the low input lane and is mirrored to the target lane.
    logic [15:0] wr_data;
    assign wr_data = wr_req_in.is_byte ? {wr_req_in.data[7:0], wr_req_in.data[7:0]}
                                       : wr_req_in.data;

    // RAM write; each lane has its own strobe so a byte write leaves the other lane intact.
    always_ff @(posedge clk_in) begin
        if (wr_reg.ram && lane_we[0]) begin
            lane_lo[word_index(wr_req_in.addr)] <= wr_data[7:0];
        end
        if (wr_reg.ram && lane_we[1]) begin
            lane_hi[word_index(wr_req_in.addr)] <= wr_data[15:8];
        end
    end

    // The whole containing word is always fetched, even for a byte read.
    always_ff @(posedge clk_in) begin
        mem_word_reg <= {lane_hi[word_index(rd_addr)], lane_lo[word_index(rd_addr)]};
    end

    // Peripheral register writes leave through lane strobes; memory never backs them.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            periph_wr_out <= 1'b0;
            periph_lane_we_out <= 2'h0;
            periph_wdata_out <= 16'h0000;
        end else begin
            periph_wr_out <= wr_do && wr_reg.periph;
            periph_lane_we_out <= wr_reg.periph ? lane_we : 2'h0;
            periph_wdata_out <= wr_data;
        end
    end

    // Peripheral address follows the read generator unless a write is active.
    assign periph_addr_out = wr_req_in.valid ? wr_req_in.addr : rd_addr;
    assign psv_rd_out = rd_req_in.valid && rd_reg.psv;

    // Read pipeline: region and byte lane captured alongside the memory fetch.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rd_pend_reg <= 1'b0;
            rd_byte_reg <= 1'b0;
            rd_sel_hi_reg <= 1'b0;
            rd_hit_reg <= 1'b0;
            rd_psv_reg <= 1'b0;
            rd_periph_reg <= 1'b0;
        end else begin
            // A misaligned read still returns data so the instruction completes.
            rd_pend_reg <= rd_req_in.valid;
            rd_byte_reg <= rd_req_in.is_byte;
            rd_sel_hi_reg <= rd_addr[0];
            rd_hit_reg <= rd_reg.ram;
            rd_psv_reg <= rd_reg.psv;
            rd_periph_reg <= rd_reg.periph && periph_hit_in;
        end
    end

    // Unimplemented locations return zero, for byte or word.
    always_comb begin
        rd_word = 16'h0000;
        if (rd_psv_reg) begin
            rd_word = psv_rdata_in;
        end else if (rd_periph_reg) begin
            rd_word = periph_rdata_in;
        end else if (rd_hit_reg) begin
            rd_word = mem_word_reg;
        end
    end

    // Data output registered; byte reads land on the low byte.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_pend_reg;
            if (rd_byte_reg) begin
                rd_data_out <= {8'h00, rd_sel_hi_reg ? rd_word[15:8] : rd_word[7:0]};
            end else begin
                rd_data_out <= rd_word;
            end
        end
    end

    // Address error is a one-cycle pulse; write errors are flagged for the trap handler.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            addr_error_out <= 1'b0;
            addr_error_write_out <= 1'b0;
            error_addr_out <= 16'h0000;
        end else begin
            addr_error_out <= rd_misaligned || wr_misaligned;
            addr_error_write_out <= wr_misaligned;
            if (wr_misaligned) begin
                error_addr_out <= wr_req_in.addr;
            end else if (rd_misaligned) begin
                error_addr_out <= rd_addr;
            end
        end
    end

    // Pointer post-increment scaled by access size.
    assign ptr_next_out = ptr_inc_in
        ? ptr_in + (rd_req_in.is_byte ? bads_pkg::STEP_BYTE : bads_pkg::STEP_WORD)
        : ptr_in;

    // Working register byte operations.
    always_comb begin
        unique case (reg_op_in)
            bads_pkg::BADS_OP_PASS: reg_result_out = reg_value_in;
            bads_pkg::BADS_OP_SIGN:
                reg_result_out = {{8{reg_value_in[7]}}, reg_value_in[7:0]};
            bads_pkg::BADS_OP_CLEAR_HIGH:
                reg_result_out = {8'h00, reg_value_in[7:0]};
            bads_pkg::BADS_OP_LOAD_BYTE:
                reg_result_out = {reg_value_in[15:8], reg_byte_in};
        endcase
    end

    // A misaligned word write must never reach memory or peripherals.
    property p_wr_suppress;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_misaligned |-> (lane_we == 2'h0) ##1 (!periph_wr_out && addr_error_write_out);
    endproperty
    a_wr_suppress: assert property (p_wr_suppress) else $error("misaligned write not suppressed");

    property p_err_pulse;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_misaligned || wr_misaligned) |=> addr_error_out;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("address error missing");

    property p_byte_no_err;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_req_in.valid && rd_req_in.is_byte && !wr_req_in.valid) |=> !addr_error_out;
    endproperty
    a_byte_no_err: assert property (p_byte_no_err) else $error("byte access trapped");

    property p_rd_complete;
        @(posedge clk_in) disable iff (!rst_b_in)
        rd_misaligned |-> ##2 rd_valid_out;
    endproperty
    a_rd_complete: assert property (p_rd_complete) else $error("misaligned read not completed");

    property p_byte_lane;
        @(posedge clk_in) disable iff (!rst_b_in)
        (wr_do && wr_req_in.is_byte) |-> ($countones(lane_we) == 1 && lane_we[1] == wr_req_in.addr[0]);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte write hit wrong lane");

    property p_byte_rd_low;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_req_in.valid && rd_req_in.is_byte) |-> ##2 rd_data_out[15:8] == 8'h00;
    endproperty
    a_byte_rd_low: assert property (p_byte_rd_low) else $error("byte read upper lane not zero");

    property p_unimpl_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_req_in.valid && !rd_reg.psv && !rd_reg.ram && !rd_reg.periph) |-> ##2 rd_data_out == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");

    property p_ptr_step;
        @(posedge clk_in) disable iff (!rst_b_in)
        ptr_inc_in |-> ptr_next_out == ptr_in + (rd_req_in.is_byte ? 16'h0001 : 16'h0002);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");

endmodule

`default_nettype wire

//--- sim/bads_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module bads_far_model (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic psv_rd_in,
    output logic hit_out,
    output logic [15:0] periph_rdata_out,
    output logic [15:0] psv_rdata_out
);
    logic [15:0] pd_reg = 16'h0;
    logic [15:0] sd_reg = 16'h0;

    // Only 0x0040..0x005f are implemented, so other control addresses must read zero.
    assign hit_out = (addr_in[15:5] == 11'h002);
    assign periph_rdata_out = pd_reg;
    assign psv_rdata_out = sd_reg;

    // Data comes a cycle late; idle lines show inverted stale data so no guess can pass.
    always @(posedge clk_in) begin
        pd_reg <= hit_out ? {addr_in[8:1], ~addr_in[8:1]} : ~pd_reg;
        sd_reg <= psv_rd_in ? ~addr_in : ~sd_reg;
    end
endmodule

`default_nettype wire

//--- sim/bads_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bads_core_tb;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    bads_pkg::bads_req_t rd_req_in = '0;
    bads_pkg::bads_req_t wr_req_in = '0;
    logic near_mode_in = 1'b0;
    logic [12:0] near_addr_in = 13'h0;
    logic [15:0] ptr_in = 16'h0;
    logic ptr_inc_in = 1'b0;
    logic [15:0] periph_rdata_in;
    logic [15:0] psv_rdata_in;
    logic periph_hit_in;
    bads_pkg::bads_op_t reg_op_in = bads_pkg::BADS_OP_PASS;
    logic [15:0] reg_value_in = 16'h0;
    logic [7:0] reg_byte_in = 8'h0;
    logic [15:0] rd_data_out, ptr_next_out, reg_result_out, periph_addr_out;
    logic [15:0] periph_wdata_out, error_addr_out;
    logic rd_valid_out, periph_wr_out, psv_rd_out, addr_error_out, addr_error_write_out;
    logic [1:0] periph_lane_we_out;
    int num_errors = 0;
    int check_count = 0;
    logic [15:0] d;
    logic e, w, p;
    logic [2:0] pw;
    logic [15:0] pa, wd;

    // Free-running 100 MHz clock.
    always #5 clk_in = ~clk_in;

    bads_core dut (.clk_in, .rst_b_in, .rd_req_in, .wr_req_in, .near_mode_in, .near_addr_in,
        .ptr_in, .ptr_inc_in, .periph_rdata_in, .periph_hit_in, .psv_rdata_in, .reg_op_in,
        .reg_value_in, .reg_byte_in, .rd_data_out, .rd_valid_out, .ptr_next_out,
        .reg_result_out, .periph_wr_out, .periph_lane_we_out, .periph_addr_out,
        .periph_wdata_out, .psv_rd_out, .addr_error_out, .addr_error_write_out,
        .error_addr_out);

    bads_far_model far (.clk_in, .addr_in(periph_addr_out), .psv_rd_in(psv_rd_out),
        .hit_out(periph_hit_in), .periph_rdata_out(periph_rdata_in),
        .psv_rdata_out(psv_rdata_in));

    // Prints the counts and the verdict, then stops the run.
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One read; the error flag is caught a cycle after the request, data after two.
    task automatic rd(input logic [15:0] a, input logic b, input logic n);
        @(posedge clk_in);
        rd_req_in <= '{1'b1, b, a, 16'h0};
        near_mode_in <= n;
        #1 p = psv_rd_out;
        pa = periph_addr_out;
        @(posedge clk_in);
        rd_req_in.valid <= 1'b0;
        near_mode_in <= 1'b0;
        #1 e = addr_error_out;
        @(posedge clk_in);
        #1;
        for (int i = 0; i < 4 && rd_valid_out !== 1'b1; i++) begin
            @(posedge clk_in);
            #1;
        end
        if (rd_valid_out !== 1'b1) begin
            num_errors++;
            $display("ERROR t=%0t read timeout", $time);
            final_report();
        end
        d = rd_data_out;
    endtask

    // One write; error flags and peripheral strobes show one cycle after the request.
    task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] v);
        @(posedge clk_in);
        wr_req_in <= '{1'b1, b, a, v};
        @(posedge clk_in);
        wr_req_in.valid <= 1'b0;
        #1 e = addr_error_out;
        w = addr_error_write_out;
        pw = {periph_wr_out, periph_lane_we_out};
        wd = periph_wdata_out;
    endtask

    task automatic t_lanes;
        wr(16'h0800, 1'b0, 16'h1234);
        wr(16'h0801, 1'b1, 16'h77a5);
        rd(16'h0800, 1'b0, 1'b0);
        chk(d, 16'ha534);
        rd(16'h0800, 1'b1, 1'b0);
        chk(d, 16'h0034);
        rd(16'h0801, 1'b1, 1'b0);
        chk(d, 16'h00a5);
        chk({15'h0, e}, 16'h0);
    endtask

    task automatic t_align;
        wr(16'h0802, 1'b0, 16'h5678);
        wr(16'h0803, 1'b0, 16'hffff);
        chk({14'h0, e, w}, 16'h3);
        chk(error_addr_out, 16'h0803);
        wr(16'h0803, 1'b1, 16'h0011);
        chk({15'h0, e}, 16'h0);
        rd(16'h0802, 1'b0, 1'b0);
        chk(d, 16'h1178);
        rd(16'h0801, 1'b0, 1'b0);
        chk({d[15:1], e}, {15'h529a, 1'b1});
        chk(error_addr_out, 16'h0801);
    endtask

    task automatic t_regions;
        wr(16'h23fe, 1'b0, 16'hbeef);
        rd(16'h23fe, 1'b0, 1'b0);
        chk(d, 16'hbeef);
        chk(pa, 16'h23fe);
        chk({15'h0, p}, 16'h0);
        rd(16'h2400, 1'b0, 1'b0);
        chk(d, 16'h0000);
        rd(16'h7ffe, 1'b1, 1'b0);
        chk(d, 16'h0000);
        rd(16'h8004, 1'b0, 1'b0);
        chk(d, 16'h7ffb);
        chk({15'h0, p}, 16'h1);
        rd(16'h0044, 1'b0, 1'b0);
        chk(d, 16'h22dd);
        chk(pa, 16'h0044);
        rd(16'h0045, 1'b1, 1'b0);
        chk(d, 16'h0022);
        rd(16'h0010, 1'b0, 1'b0);
        chk(d, 16'h0000);
        @(posedge clk_in);
        near_addr_in <= 13'h0800;
        rd(16'h3000, 1'b0, 1'b1);
        chk(d, 16'ha534);
        chk(pa, 16'h0800);
    endtask

    // Read and write generators work in the same cycle on different words.
    task automatic t_dual;
        @(posedge clk_in);
        rd_req_in <= '{1'b1, 1'b0, 16'h0800, 16'h0};
        wr_req_in <= '{1'b1, 1'b0, 16'h0804, 16'hcafe};
        @(posedge clk_in);
        rd_req_in.valid <= 1'b0;
        wr_req_in.valid <= 1'b0;
        @(posedge clk_in);
        #1 chk({15'h0, rd_valid_out}, 16'h1);
        chk(rd_data_out, 16'ha534);
        rd(16'h0805, 1'b1, 1'b0);
        chk(d, 16'h00ca);
    endtask

    task automatic t_periph_wr;
        wr(16'h0045, 1'b1, 16'h00c3);
        chk({13'h0, pw}, 16'h6);
        chk({8'h00, wd[15:8]}, 16'h00c3);
        wr(16'h0044, 1'b0, 16'h1234);
        chk({13'h0, pw}, 16'h7);
        chk(wd, 16'h1234);
        wr(16'h0045, 1'b0, 16'h1234);
        chk({12'h0, pw, e}, 16'h1);
    endtask

    task automatic t_ptr;
        @(posedge clk_in);
        ptr_in <= 16'h0100;
        ptr_inc_in <= 1'b1;
        rd_req_in.is_byte <= 1'b1;
        #1 chk(ptr_next_out, 16'h0101);
        @(posedge clk_in);
        ptr_in <= 16'hfffe;
        rd_req_in.is_byte <= 1'b0;
        #1 chk(ptr_next_out, 16'h0000);
    endtask

    task automatic op(input bads_pkg::bads_op_t o, input logic [15:0] v, input logic [7:0] b);
        @(posedge clk_in);
        reg_op_in <= o;
        reg_value_in <= v;
        reg_byte_in <= b;
        #1;
    endtask

    task automatic t_ops;
        op(bads_pkg::BADS_OP_SIGN, 16'h3480, 8'h80);
        chk(reg_result_out, 16'hff80);
        op(bads_pkg::BADS_OP_SIGN, 16'h127f, 8'h7f);
        chk(reg_result_out, 16'h007f);
        op(bads_pkg::BADS_OP_CLEAR_HIGH, 16'habcd, 8'hcd);
        chk(reg_result_out, 16'h00cd);
        op(bads_pkg::BADS_OP_LOAD_BYTE, 16'habcd, 8'h12);
        chk(reg_result_out, 16'hab12);
        op(bads_pkg::BADS_OP_PASS, 16'h1234, 8'h00);
        chk(reg_result_out, 16'h1234);
    endtask

    // Reset for five cycles, then run every scenario once.
    initial begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_lanes();
        t_align();
        t_regions();
        t_dual();
        t_periph_wr();
        t_ptr();
        t_ops();
        final_report();
    end
endmodule

`default_nettype wire
